// >>> spmc_serial_port.sv
// Purpose: Serial port with modem handshake, carrier gating and ring filter.
// Assumes: Modem pins and bit clocks are asynchronous to clk.
// Notes: Transmit bytes pass a two-entry buffer; a full buffer stalls APB writes to TXD.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module spmc_serial_port (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic txLine,
    input wire logic rxLine,
    output logic rtsOut,
    input wire logic ctsIn,
    output logic dtrOut,
    input wire logic dsrIn,
    input wire logic dcdIn,
    input wire logic ringIn,
    output logic ringDetect,
    input wire logic txClkIn,
    input wire logic rxClkIn
);

    // Two-stage synchronisers for all modem inputs, stage one and two.
    logic [6:0] syncA_reg;
    logic [6:0] syncB_reg;
    // Previous samples of the bit clocks for edge detection.
    logic txClkOld_reg;
    logic rxClkOld_reg;

    // Control, divider and ring threshold registers.
    logic [3:0] ctrl_reg;
    logic [15:0] div_reg;
    logic [15:0] ringThr_reg;

    // Two-entry transmit buffer.
    logic [7:0] buf_reg [2];
    logic wrPtr_reg;
    logic rdPtr_reg;
    logic [1:0] count_reg;

    // Transmitter state.
    spmc_pkg::spmc_tx_e txState_reg;
    logic [7:0] txSh_reg;
    logic [3:0] txBits_reg;
    logic txStop_reg;
    logic [15:0] txCnt_reg;

    // Receiver state.
    spmc_pkg::spmc_rx_e rxState_reg;
    logic [7:0] rxSh_reg;
    logic [3:0] rxBits_reg;
    logic [15:0] rxCnt_reg;
    logic [7:0] rxByte_reg;
    logic rxValid_reg;
    logic overrun_reg;
    logic frameErr_reg;

    // Terminal-ready lockout and ring integrator.
    logic dtrLock_reg;
    logic [15:0] ringCnt_reg;

    // Synchronised inputs named by use.
    wire ctsS = syncB_reg[0];
    wire dsrS = syncB_reg[1];
    wire dcdS = syncB_reg[2];
    wire ringS = syncB_reg[3];
    wire rxS = syncB_reg[4];
    wire txClkS = syncB_reg[5];
    wire rxClkS = syncB_reg[6];

    // Mode bits.
    wire syncMode = ctrl_reg[spmc_pkg::CTRL_SYNC];
    wire stop2 = ctrl_reg[spmc_pkg::CTRL_STOP2];

    // Bit clock edges, found from synchronised samples only.
    wire txClkRise = txClkS & ~txClkOld_reg;
    wire rxClkFall = ~rxClkS & rxClkOld_reg;

    // APB decode.
    wire access = psel & penable & ~pready;
    wire done = psel & penable & pready;
    wire isCtrl = paddr == spmc_pkg::ADDR_CTRL;
    wire isDiv = paddr == spmc_pkg::ADDR_DIV;
    wire isTxd = paddr == spmc_pkg::ADDR_TXD;
    wire isRxd = paddr == spmc_pkg::ADDR_RXD;
    wire isStat = paddr == spmc_pkg::ADDR_STAT;
    wire isRing = paddr == spmc_pkg::ADDR_RING;
    wire mapped = isCtrl | isDiv | isTxd | isRxd | isStat | isRing;
    wire bufFull = count_reg == 2'h2;
    // A write to a full buffer holds pready low until a byte leaves.
    wire stall = access & pwrite & isTxd & bufFull;
    wire wrDone = done & pwrite;
    wire push = wrDone & isTxd;
    wire rxdRead = done & ~pwrite & isRxd;

    wire canSend = rtsOut & ctsS;
    // Async bit tick from the divider, sync tick on the clock rising edge.
    // rising edge drive
    wire txTick = syncMode ? txClkRise : (txCnt_reg == 16'h0000);
    wire pop = (txState_reg == spmc_pkg::TX_IDLE) & txTick & canSend & (count_reg != 2'h0);
    wire [7:0] head = buf_reg[rdPtr_reg];
    wire rxTick = rxCnt_reg == 16'h0000;
    wire deliver;

    // Status word gathered for reads.
    wire [31:0] statWord = {22'h000000, count_reg, frameErr_reg, overrun_reg,
                            ringDetect, dcdS, dsrS, ctsS, rxValid_reg,
                            txState_reg != spmc_pkg::TX_IDLE};

    // Read data selection.
    wire [31:0] readMux = isCtrl ? {28'h0000000, ctrl_reg} :
                          isDiv ? {16'h0000, div_reg} :
                          isRxd ? {24'h000000, rxByte_reg} :
                          isStat ? statWord :
                          isRing ? {16'h0000, ringThr_reg} : 32'h00000000;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncA_reg <= 7'h00;
            syncB_reg <= 7'h00;
            txClkOld_reg <= 1'b0;
            rxClkOld_reg <= 1'b0;
        end else begin
            syncA_reg <= {rxClkIn, txClkIn, rxLine, ringIn, dcdIn, dsrIn, ctsIn};
            syncB_reg <= syncA_reg;
            txClkOld_reg <= txClkS;
            rxClkOld_reg <= rxClkS;
        end
    end

    // APB answer one cycle into the access phase, unless stalled.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= access & ~stall;
            pslverr <= access & ~stall & ~mapped;
            prdata <= readMux;
        end
    end

    // Register writes take effect at the completing edge.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= spmc_pkg::CTRL_RST;
            div_reg <= spmc_pkg::DIV_RST;
            ringThr_reg <= spmc_pkg::RING_RST;
        end else if (wrDone) begin
            if (isCtrl) begin
                ctrl_reg <= pwdata[3:0];
            end
            if (isDiv) begin
                div_reg <= pwdata[15:0];
            end
            if (isRing) begin
                ringThr_reg <= pwdata[15:0];
            end
        end
    end

    // Transmit buffer: written by APB, drained by the transmitter.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_reg <= 1'b0;
            rdPtr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (push) begin
                wrPtr_reg <= ~wrPtr_reg;
            end
            if (pop) begin
                rdPtr_reg <= ~rdPtr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    // Buffer storage needs no reset; count marks what is valid.
    always_ff @(posedge clk) begin
        if (push) begin
            buf_reg[wrPtr_reg] <= pwdata[7:0];
        end
    end

    // Async bit-time divider for the transmitter.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txCnt_reg <= 16'h0000;
        end else begin
            txCnt_reg <= (txCnt_reg == 16'h0000) ? div_reg : txCnt_reg - 16'h0001;
        end
    end

    // Transmitter; the line idles high (mark).
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txState_reg <= spmc_pkg::TX_IDLE;
            txLine <= 1'b1;
            txSh_reg <= 8'h00;
            txBits_reg <= 4'h0;
            txStop_reg <= 1'b0;
        end else if (txTick) begin
            case (txState_reg)
                spmc_pkg::TX_IDLE: begin
                    if (pop) begin
                        txState_reg <= spmc_pkg::TX_DATA;
                        if (syncMode) begin
                            // Sync: first data bit goes out at once.
                            txLine <= head[0];
                            txSh_reg <= {1'b0, head[7:1]};
                            txBits_reg <= spmc_pkg::SYNC_BITS;
                        end else begin
                            txLine <= 1'b0;
                            txSh_reg <= head;
                            txBits_reg <= spmc_pkg::ASYNC_BITS;
                        end
                    end
                end
                spmc_pkg::TX_DATA: begin
                    if (txBits_reg != 4'h0) begin
                        txLine <= txSh_reg[0];
                        txSh_reg <= {1'b0, txSh_reg[7:1]};
                        txBits_reg <= txBits_reg - 4'h1;
                    end else if (syncMode) begin
                        txLine <= 1'b1;
                        txState_reg <= spmc_pkg::TX_IDLE;
                    end else begin
                        txLine <= 1'b1;
                        txStop_reg <= stop2;
                        txState_reg <= spmc_pkg::TX_STOP;
                    end
                end
                spmc_pkg::TX_STOP: begin
                    // A second stop bit holds the line one tick more.
                    if (txStop_reg) begin
                        txStop_reg <= 1'b0;
                    end else begin
                        txState_reg <= spmc_pkg::TX_IDLE;
                    end
                end
                default: begin
                    txState_reg <= spmc_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // A character is complete at the last sync bit or a good async stop, and never without carrier.
    assign deliver = dcdS & (syncMode ? (rxClkFall & (rxBits_reg == spmc_pkg::SYNC_BITS))
                                      : ((rxState_reg == spmc_pkg::RX_STOP) & rxTick & rxS));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxState_reg <= spmc_pkg::RX_IDLE;
            rxSh_reg <= 8'h00;
            rxBits_reg <= 4'h0;
            rxCnt_reg <= 16'h0000;
        end else if (!dcdS) begin
            rxState_reg <= spmc_pkg::RX_IDLE;
            rxBits_reg <= 4'h0;
            rxCnt_reg <= 16'h0000;
        end else if (syncMode) begin
            if (rxClkFall) begin
                rxSh_reg <= {rxS, rxSh_reg[7:1]};
                rxBits_reg <= deliver ? 4'h0 : rxBits_reg + 4'h1;
            end
        end else begin
            rxCnt_reg <= rxTick ? div_reg : rxCnt_reg - 16'h0001;
            case (rxState_reg)
                spmc_pkg::RX_IDLE: begin
                    // Start edge: wait half a bit to reach the centre.
                    if (!rxS) begin
                        rxCnt_reg <= {1'b0, div_reg[15:1]};
                        rxState_reg <= spmc_pkg::RX_START;
                    end
                end
                spmc_pkg::RX_START: begin
                    // A glitch that is high at the centre is dropped.
                    if (rxTick) begin
                        rxBits_reg <= 4'h0;
                        rxState_reg <= rxS ? spmc_pkg::RX_IDLE : spmc_pkg::RX_DATA;
                    end
                end
                spmc_pkg::RX_DATA: begin
                    if (rxTick) begin
                        rxSh_reg <= {rxS, rxSh_reg[7:1]};
                        rxBits_reg <= rxBits_reg + 4'h1;
                        if (rxBits_reg == spmc_pkg::SYNC_BITS) begin
                            rxState_reg <= spmc_pkg::RX_STOP;
                        end
                    end
                end
                spmc_pkg::RX_STOP: begin
                    if (rxTick) begin
                        // Clear the bit count so a later switch to sync mode starts a fresh byte.
                        rxBits_reg <= 4'h0;
                        rxState_reg <= spmc_pkg::RX_IDLE;
                    end
                end
                default: begin
                    rxState_reg <= spmc_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // Received byte and sticky flags; a new event wins over a read.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxByte_reg <= 8'h00;
            rxValid_reg <= 1'b0;
            overrun_reg <= 1'b0;
            frameErr_reg <= 1'b0;
        end else begin
            if (deliver) begin
                rxByte_reg <= syncMode ? {rxS, rxSh_reg[7:1]} : rxSh_reg;
                rxValid_reg <= 1'b1;
                overrun_reg <= overrun_reg | (rxValid_reg & ~rxdRead);
            end else if (rxdRead) begin
                rxValid_reg <= 1'b0;
                overrun_reg <= 1'b0;
            end
            if (!syncMode & dcdS & (rxState_reg == spmc_pkg::RX_STOP) & rxTick & ~rxS) begin
                frameErr_reg <= 1'b1;
            end else if (rxdRead) begin
                frameErr_reg <= 1'b0;
            end
        end
    end

    // Modem control outputs; no transmit clock is ever driven out.
    // no clock out
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rtsOut <= 1'b0;
            dtrOut <= 1'b0;
            dtrLock_reg <= 1'b0;
        end else begin
            rtsOut <= ctrl_reg[spmc_pkg::CTRL_RTS];
            dtrOut <= ctrl_reg[spmc_pkg::CTRL_DTR] & (dtrOut | ~dtrLock_reg);
            if (dtrOut & ~ctrl_reg[spmc_pkg::CTRL_DTR]) begin
                dtrLock_reg <= 1'b1;
            end else if (!dsrS) begin
                dtrLock_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ringCnt_reg <= 16'h0000;
            ringDetect <= 1'b0;
        end else if (!ringS) begin
            ringCnt_reg <= 16'h0000;
            ringDetect <= 1'b0;
        end else if (ringCnt_reg >= ringThr_reg) begin
            ringDetect <= 1'b1;
        end else begin
            ringCnt_reg <= ringCnt_reg + 16'h0001;
        end
    end

    // Start of a transmitted character.
    sequence s_txStart;
        txState_reg == spmc_pkg::TX_IDLE ##1 txState_reg == spmc_pkg::TX_DATA;
    endsequence

    // Terminal-ready was dropped while the modem still reports ready.
    sequence s_dtrHeld;
        dtrLock_reg && dsrS;
    endsequence

    property p_ctsGate;
        @(posedge clk) disable iff (!rstn)
        (txState_reg == spmc_pkg::TX_IDLE && !(rtsOut && ctsS)) |=> txState_reg == spmc_pkg::TX_IDLE;
    endproperty
    a_ctsGate: assert property (p_ctsGate) else $error("transmit started without handshake");

    property p_startBit;
        @(posedge clk) disable iff (!rstn)
        (s_txStart ##0 !syncMode) |-> !txLine;
    endproperty
    a_startBit: assert property (p_startBit) else $error("missing start bit");

    property p_lsbFirst;
        @(posedge clk) disable iff (!rstn)
        (txState_reg == spmc_pkg::TX_DATA && txTick && txBits_reg != 4'h0) |=> txLine == $past(txSh_reg[0]);
    endproperty
    a_lsbFirst: assert property (p_lsbFirst) else $error("wrong data bit order");

    property p_syncTxEdge;
        @(posedge clk) disable iff (!rstn)
        (syncMode && !txClkRise) |=> $stable(txLine);
    endproperty
    a_syncTxEdge: assert property (p_syncTxEdge) else $error("sync line moved off rising edge");

    property p_carrierIdle;
        @(posedge clk) disable iff (!rstn)
        !dcdS |=> (rxState_reg == spmc_pkg::RX_IDLE && rxBits_reg == 4'h0);
    endproperty
    a_carrierIdle: assert property (p_carrierIdle) else $error("receiver active without carrier");

    property p_syncRxSample;
        @(posedge clk) disable iff (!rstn)
        (syncMode && dcdS && rxClkFall && !deliver) |=> rxSh_reg[7] == $past(rxS);
    endproperty
    a_syncRxSample: assert property (p_syncRxSample) else $error("sync receive not sampled");

    property p_dtrHold;
        @(posedge clk) disable iff (!rstn)
        s_dtrHeld |=> !dtrOut;
    endproperty
    a_dtrHold: assert property (p_dtrHold) else $error("terminal ready raised too early");

    property p_ringFilter;
        @(posedge clk) disable iff (!rstn)
        $rose(ringDetect) |-> ($past(ringS, 1) && ringCnt_reg >= ringThr_reg);
    endproperty
    a_ringFilter: assert property (p_ringFilter) else $error("ring reported too soon");

    property p_ringDrop;
        @(posedge clk) disable iff (!rstn)
        !ringS |=> !ringDetect;
    endproperty
    a_ringDrop: assert property (p_ringDrop) else $error("ring kept after input fell");

endmodule

// >>> spmc_pkg.sv
// Purpose: Constants and types for the serial port modem control block.
// Assumes: 10 MHz system clock, APB register access, byte characters.
// Notes: Each rule below is tagged at the logic that keeps it.
package spmc_pkg;

    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DIV = 8'h04;
    localparam logic [7:0] ADDR_TXD = 8'h08;
    localparam logic [7:0] ADDR_RXD = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [7:0] ADDR_RING = 8'h14;

    // Control register field positions.
    localparam int CTRL_RTS = 0;
    localparam int CTRL_DTR = 1;
    localparam int CTRL_SYNC = 2;
    localparam int CTRL_STOP2 = 3;

    // Values after reset.
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [15:0] DIV_RST = 16'h0411;
    localparam logic [15:0] RING_RST = 16'h03E8;

    // Bits of a character and count loaded at the start of a sync frame.
    localparam logic [3:0] ASYNC_BITS = 4'h8;
    localparam logic [3:0] SYNC_BITS = 4'h7;

    // Transmitter and receiver states.
    typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_STOP} spmc_tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spmc_rx_e;

endpackage

// >>> spmc_modem_model.sv
// Purpose: Modem model that faces the serial port in the bench.
// Assumes: Async bit time of 8 clk; link clocks have an 800 ns period.
// Notes: Link clocks stand still outside frames; idle data line is mark (high).
`timescale 1ns/1ps
module spmc_modem_model (
    input wire logic clk,
    input wire logic rtsOut,
    input wire logic txLine,
    input wire logic ctsHold,
    output logic ctsIn,
    output logic rxLine,
    output logic txClkIn,
    output logic rxClkIn
);
    localparam int BIT_CLK = 8; // Clock cycles in one async bit.
    int ctsCnt = 0; // Cycles since request rose, saturating at the answer delay.

    // Lines start idle and clocks stopped.
    initial begin
        ctsIn = 1'b0;
        rxLine = 1'b1;
        txClkIn = 1'b0;
        rxClkIn = 1'b0;
    end

    // request drives turnaround
    // Clear-to-send answers request slowly, or is held high when the bench commands it.
    always @(posedge clk) begin
        ctsCnt <= rtsOut ? ((ctsCnt < 40) ? ctsCnt + 1 : ctsCnt) : 0;
        ctsIn <= ctsHold | (rtsOut & (ctsCnt == 40));
    end

    // async frame sent
    // Sends start, eight bits least significant first, then one stop bit.
    task automatic sendAsync(input logic [7:0] b);
        rxLine <= 1'b0;
        repeat (BIT_CLK) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            rxLine <= (i < 8) ? b[i] : 1'b1;
            repeat (BIT_CLK) @(posedge clk);
        end
    endtask

    // Captures one async character at bit centres and reports the stop level.
    task automatic recvAsync(output logic [7:0] b, output logic stopBit);
        while (txLine !== 1'b0) @(posedge clk);
        repeat (BIT_CLK / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLK) @(posedge clk);
            b[i] = txLine;
        end
        repeat (BIT_CLK) @(posedge clk);
        stopBit = txLine;
    endtask

    // sync clock edges
    // Runs both clocks for nine 8-cycle periods: receive data changes on rises, transmit data is taken at falls.
    task automatic syncXfer(input logic [7:0] rb, output logic [7:0] tb);
        for (int i = 0; i < 9; i++) begin
            txClkIn <= 1'b1;
            rxClkIn <= 1'b1;
            rxLine <= (i < 8) ? rb[i] : 1'b1;
            repeat (2) @(posedge clk);
            rxClkIn <= 1'b0;
            repeat (4) @(posedge clk);
            if (i < 8) tb[i] = txLine;
            txClkIn <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
endmodule

// >>> serial_port_modem_control_tb.sv
// Purpose: Self-checking bench for the serial port with modem control.
// Assumes: DIV set to 7 (8 clk bits) and RING set to 3.
// Notes: Expected transmit bytes live in a queue filled by the bench itself.
`timescale 1ns/1ps
module serial_port_modem_control_tb;
    logic clk = 1'b0; // System clock, 100 ns period.
    logic rstn, psel, penable, pwrite; // Reset and APB controls.
    logic [7:0] paddr; // APB address.
    logic [31:0] pwdata, prdata; // APB data.
    logic pready, pslverr, txLine, rxLine, rtsOut, ctsIn, dtrOut; // Port outputs and modem lines.
    logic dsrIn, dcdIn, ringIn, ringDetect, txClkIn, rxClkIn, ctsHold; // Modem status and clocks.
    logic [31:0] rdat; // Last read data.
    logic rerr; // Last error response.
    logic [7:0] b, got; // Scratch bytes.
    logic stp, ringSeen; // Stop level and sticky ring flag.
    logic [7:0] regAddr[4] = '{spmc_pkg::ADDR_CTRL, spmc_pkg::ADDR_DIV, spmc_pkg::ADDR_RING, 8'h18}; // Probed offsets.
    logic [31:0] regRst[4] = '{32'h0, 32'h411, 32'h3E8, 32'h0}; // Values expected after reset.
    logic [7:0] txQ[$]; // Bytes expected on the line.
    int seed = 32'h3C00B5AB; // Fixed random seed.
    int miscompares = 0; // Mismatch count.
    int checks = 0; // Comparison count.
    int cycles = 0; // Timeout counter.

    // Clock generator.
    initial forever #50 clk = ~clk;

    spmc_serial_port dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .txLine(txLine), .rxLine(rxLine), .rtsOut(rtsOut), .ctsIn(ctsIn), .dtrOut(dtrOut),
        .dsrIn(dsrIn), .dcdIn(dcdIn), .ringIn(ringIn), .ringDetect(ringDetect),
        .txClkIn(txClkIn), .rxClkIn(rxClkIn));

    spmc_modem_model modem (.clk(clk), .rtsOut(rtsOut), .txLine(txLine), .ctsHold(ctsHold),
        .ctsIn(ctsIn), .rxLine(rxLine), .txClkIn(txClkIn), .rxClkIn(rxClkIn));

    // Prints the counts and the verdict, then stops.
    task wrap_up;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One APB transfer; waits for pready, then lets one edge pass before the next request.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // Checks that the transmit line stays idle for n cycles.
    task automatic idleFor(input int n);
        int bad;
        bad = 0;
        repeat (n) begin
            @(posedge clk);
            if (txLine !== 1'b1) bad++;
        end
        chk(bad, 0);
    endtask

    // Cuts a hang short and remembers any ring report.
    always @(posedge clk) begin
        cycles++;
        if (ringDetect === 1'b1) ringSeen <= 1'b1;
        if (cycles > 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    // Main sequence.
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        dsrIn = 1'b0;
        dcdIn = 1'b0;
        ringIn = 1'b0;
        ctsHold = 1'b0;
        ringSeen = 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk(txLine, 1); // idle mark
        chk(rtsOut, 0); // no request
        foreach (regAddr[i]) begin
            apb(1'b0, regAddr[i], 32'h0);
            chk(rdat, regRst[i]);
            chk(rerr, (i == 3) ? 1 : 0);
        end
        apb(1'b1, spmc_pkg::ADDR_DIV, 32'h7);
        apb(1'b1, spmc_pkg::ADDR_RING, 32'h3);
        apb(1'b0, spmc_pkg::ADDR_DIV, 32'h0);
        chk(rdat, 32'h7);
        // Two bytes queued while clear-to-send is held high without a request.
        ctsHold <= 1'b1;
        for (int i = 0; i < 3; i++) txQ.push_back((i == 0) ? 8'hA5 : 8'($random(seed)));
        apb(1'b1, spmc_pkg::ADDR_TXD, {24'h0, txQ[0]});
        apb(1'b1, spmc_pkg::ADDR_TXD, {24'h0, txQ[1]});
        idleFor(60); // cts alone ignored
        ctsHold <= 1'b0;
        apb(1'b1, spmc_pkg::ADDR_CTRL, 32'h9); // request with two stop bits
        idleFor(35); // wait for cts
        // Third write stalls on the full buffer while frames go out back to back.
        fork
            apb(1'b1, spmc_pkg::ADDR_TXD, {24'h0, txQ[2]});
            repeat (3) begin
                modem.recvAsync(got, stp);
                chk(got, txQ.pop_front()); // lsb first
                chk(stp, 1); // stop bit
                repeat (16) @(posedge clk);
                chk(txLine, 1); // second stop bit
            end
        join
        // Receiver without carrier, then with carrier.
        modem.sendAsync(8'h3C);
        apb(1'b0, spmc_pkg::ADDR_STAT, 32'h0);
        chk(rdat[1], 0); // no byte received without carrier
        dcdIn <= 1'b1;
        repeat (5) @(posedge clk);
        b = 8'($random(seed));
        modem.sendAsync(b);
        repeat (8) @(posedge clk);
        apb(1'b0, spmc_pkg::ADDR_RXD, 32'h0);
        chk(rdat, {24'h0, b}); // same format
        // Synchronous mode in both directions.
        dcdIn <= 1'b0;
        apb(1'b1, spmc_pkg::ADDR_CTRL, 32'h5);
        dcdIn <= 1'b1;
        b = 8'($random(seed));
        apb(1'b1, spmc_pkg::ADDR_TXD, {24'h0, b});
        repeat (6) @(posedge clk);
        modem.syncXfer(~b, got);
        @(posedge clk);
        chk(got, b); // sync transmit
        repeat (6) @(posedge clk);
        apb(1'b0, spmc_pkg::ADDR_RXD, 32'h0);
        chk(rdat, {24'h0, ~b}); // sync receive
        // Terminal-ready call set up and teardown.
        // local modem ready
        dsrIn <= 1'b1;
        apb(1'b1, spmc_pkg::ADDR_CTRL, 32'h2);
        repeat (2) @(posedge clk);
        chk(dtrOut, 1); // ready raised
        apb(1'b1, spmc_pkg::ADDR_CTRL, 32'h0);
        apb(1'b1, spmc_pkg::ADDR_CTRL, 32'h2);
        repeat (5) @(posedge clk);
        chk(dtrOut, 0); // held until dsr drops
        dsrIn <= 1'b0;
        repeat (6) @(posedge clk);
        chk(dtrOut, 1); // raised after dsr drop
        // Ring spike just short of the threshold, then a real ring.
        ringIn <= 1'b1;
        repeat (3) @(posedge clk);
        ringIn <= 1'b0;
        repeat (8) @(posedge clk);
        chk(ringSeen, 0); // spike filtered
        ringIn <= 1'b1;
        repeat (10) @(posedge clk);
        chk(ringDetect, 1); // ring reported
        ringIn <= 1'b0;
        repeat (5) @(posedge clk);
        chk(ringDetect, 0); // ring cleared
        wrap_up();
    end
endmodule
